// file: common/lwpf_pkg.sv
package lwpf_pkg;

    // ----------------------------------------------------------------
    // Bus and sizes
    // ----------------------------------------------------------------
    localparam int ADDR_W = 6;
    localparam int DATA_W = 32;
    localparam int NUM_PINS = 16;
    localparam int NUM_MODS = 8;
    localparam int NUM_FILT = 2;
    localparam int IDX_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_PIN_EDGE = 4'h0;
    localparam logic [IDX_W-1:0] IDX_MOD_EN = 4'h4;
    localparam logic [IDX_W-1:0] IDX_PIN_FLAG = 4'h5;
    localparam logic [IDX_W-1:0] IDX_FILT_ONE = 4'h8;
    localparam logic [IDX_W-1:0] IDX_FILT_TWO = 4'h9;
    localparam logic [IDX_W-1:0] IDX_STATUS = 4'ha;

    // ----------------------------------------------------------------
    // Filter register fields
    // ----------------------------------------------------------------
    localparam int FILT_REG_W = 8;
    localparam int FILT_FLAG_BIT = 7;
    localparam int FILT_EDGE_LO = 5;
    localparam int FILT_EDGE_W = 2;
    localparam int FILT_RSVD_BIT = 4;
    localparam int FILT_SEL_LO = 0;
    localparam int FILT_SEL_W = 4;
    localparam logic [FILT_EDGE_W-1:0] FILT_EDGE_RESET = 2'h0;
    localparam logic [FILT_SEL_W-1:0] FILT_SEL_RESET = 4'h0;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'h0,
        EDGE_RISE = 2'h1,
        EDGE_FALL = 2'h2,
        EDGE_ANY = 2'h3
    } lwpf_edge_t;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int STAT_ISO_BIT = 0;
    localparam int STAT_WAKE_RST_BIT = 1;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int LPO_PERIOD_US = 1000;
    localparam int LPO_DIV = (LPO_PERIOD_US * 1000) / CLK_PERIOD_NS;
    localparam int FILT_CYCLES = 3;
    localparam int SYNC_CYCLES = 2;
    localparam int ALERT_CYCLES = 5;

endpackage

// file: hw/lwpf_pin_filter.sv
`timescale 1ns/1ps
module lwpf_pin_filter #(
    parameter int FILT_CYCLES = lwpf_pkg::FILT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Control
    input wire logic lpoTick,
    input wire logic active,
    input wire logic [1:0] edgeSel,
    // Synchronised pin level and its previous sample
    input wire logic pinLevel,
    input wire logic pinPrev,
    // Result
    output logic detect
);

    localparam int CW = $clog2(FILT_CYCLES + 1);

    logic busy;
    logic wantLevel;
    logic [CW-1:0] count;
    logic rise;
    logic fall;
    logic qualEdge;

    assign rise = pinLevel && !pinPrev;
    assign fall = !pinLevel && pinPrev;
    always_comb begin
        case (edgeSel)
            lwpf_pkg::EDGE_RISE: qualEdge = rise;
            lwpf_pkg::EDGE_FALL: qualEdge = fall;
            lwpf_pkg::EDGE_ANY: qualEdge = rise || fall;
            default: qualEdge = 1'b0;
        endcase
    end

    // ----------------------------------------------------------------
    // Glitch counter, advanced once per oscillator tick
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            busy <= 1'b0;
            wantLevel <= 1'b0;
            count <= '0;
            detect <= 1'b0;
        end else begin
            detect <= 1'b0;
            if (!active || edgeSel == lwpf_pkg::EDGE_OFF) begin // R2
                busy <= 1'b0;
                count <= '0;
            end else if (lpoTick) begin
                if (!busy) begin
                    if (qualEdge) begin // R7
                        busy <= 1'b1;
                        wantLevel <= pinLevel;
                        count <= CW'(1);
                    end
                end else if (pinLevel != wantLevel) begin
                    busy <= 1'b0; // R21
                    count <= '0;
                end else if (count == CW'(FILT_CYCLES - 1)) begin
                    busy <= 1'b0; // R8
                    count <= '0;
                    detect <= 1'b1;
                end else begin
                    count <= count + CW'(1);
                end
            end
        end
    end

    AST_FILT_OFF_SILENT: assert property (@(posedge core_clk) disable iff (!arst_n) // R2
        (edgeSel == lwpf_pkg::EDGE_OFF) [*2] |-> !detect)
        else $error("filter fired while disabled");

    AST_FILT_HELD_LEVEL: assert property (@(posedge core_clk) disable iff (!arst_n) // R8
        $rose(detect) |-> $past(pinLevel) == $past(wantLevel) && $past(busy))
        else $error("filter fired without a held level");

endmodule

// file: hw/lwpf_wakeup_unit.sv
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ps
// Summary of operation
// (R1) Filter flag bit 7 sets on a filtered-pin wakeup, clears only by writing one.
// (R2) Edge field bits 6-5: off, rising, falling or either edge.
// (R3) Bit 4 of a filter register ignores writes and reads zero.
// (R4) Select field bits 3-0 routes one of sixteen pins into the filter.
// (R5) Filter registers reset only by the chip reset, not by other resets.
// (R6) Detection works only in low-leakage or very-low-leakage stop.
// (R7) Each external pin has its own off, rising, falling or either-edge setting.
// (R8) An enabled filter needs the pin held for three oscillator cycles.
// (R9) Synchronising adds up to two cycles, five in total when filtered.
// (R10) Exactly two pin filters exist.
// (R11) Internal module wakeups bypass the glitch filters.
// (R12) A module wakes the chip only while its enable bit is set.
// (R13) In low-leakage stop a wakeup starts an interrupt flow.
// (R14) In very-low-leakage stop a wakeup resets and sets the wakeup status.
// (R15) Pins stay isolated after that reset until software acknowledges.
// (R16) Software clears enabled peripheral flags before entering a low-leakage mode.
// (R17) Software clears all pin and filter flags before entering a low-leakage mode.
// (R18) Software waits five oscillator cycles after filter changes before entering.
// (R19) Software restores pin setup before acknowledging isolation.
// (R20) Wakeup pins must be muxed as digital inputs.
// (R21) A pin released mid-count discards the count and waits for a new edge.
module lwpf_wakeup_unit #(
    parameter int LPO_DIV = lwpf_pkg::LPO_DIV,
    parameter int NUM_PINS = lwpf_pkg::NUM_PINS,
    parameter int NUM_MODS = lwpf_pkg::NUM_MODS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // AXI4-Lite write
    input wire logic awvalid,
    output logic awready,
    input wire logic [lwpf_pkg::ADDR_W-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [lwpf_pkg::DATA_W-1:0] wdata,
    input wire logic [lwpf_pkg::DATA_W/8-1:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read
    input wire logic arvalid,
    output logic arready,
    input wire logic [lwpf_pkg::ADDR_W-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [lwpf_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // Wakeup sources and power mode
    input wire logic [NUM_PINS-1:0] wakeupPin,
    input wire logic [NUM_MODS-1:0] moduleWakeup,
    input wire logic lowLeakageStop,
    input wire logic veryLowLeakageStop,
    // Wakeup results
    output logic llsWakeIrq,
    output logic vllsResetReq,
    output logic resetStatusWakeup,
    output logic ioIsolate
);

    localparam int DW = lwpf_pkg::DATA_W;
    localparam int IW = lwpf_pkg::IDX_W;
    localparam int DIVW = $clog2(LPO_DIV);
    localparam int SELW = lwpf_pkg::FILT_SEL_W;
    localparam int EW = lwpf_pkg::FILT_EDGE_W;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_WATCH = 3'b010,
        ST_ISO = 3'b100
    } lwpf_state_t;

    lwpf_state_t state;
    logic [DIVW-1:0] divCount;
    logic lpoTick;
    logic [NUM_PINS-1:0] pinSyncA;
    logic [NUM_PINS-1:0] pinSyncB;
    logic [NUM_PINS-1:0] pinPrev;
    logic [2*NUM_PINS-1:0] pinEdge;
    logic [NUM_PINS-1:0] pinFlag;
    logic [NUM_PINS-1:0] pinHit;
    logic [NUM_MODS-1:0] moduleWakeupEnable;
    logic [lwpf_pkg::NUM_FILT-1:0] filterDetectFlag;
    logic [EW-1:0] filterEdgeSelect [lwpf_pkg::NUM_FILT];
    logic [SELW-1:0] filterPinSelect [lwpf_pkg::NUM_FILT];
    logic [lwpf_pkg::NUM_FILT-1:0] filtDet;
    logic armed;
    logic moduleCause;
    logic wakeCause;
    logic awHeld;
    logic wHeld;
    logic [IW-1:0] awIdx;
    logic [DW-1:0] wDataQ;
    logic [DW/8-1:0] wStrbQ;
    logic wrDo;
    logic [DW-1:0] wrMask;
    logic [DW-1:0] wrBits;
    logic wrHit;
    logic [DW-1:0] next_rdata;
    logic rdHit;
    logic [IW-1:0] arIdx;
    logic ackWrite;

    // ----------------------------------------------------------------
    // Oscillator tick divider
    // ----------------------------------------------------------------
    // The low-power oscillator is modelled as a tick enable so the whole
    // unit stays in one clock domain.
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            divCount <= '0;
            lpoTick <= 1'b0;
        end else begin
            lpoTick <= (divCount == DIVW'(LPO_DIV - 1));
            if (divCount == DIVW'(LPO_DIV - 1)) begin
                divCount <= '0;
            end else begin
                divCount <= divCount + DIVW'(1);
            end
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers, sampled at the oscillator rate
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinSyncA <= '0;
            pinSyncB <= '0;
            pinPrev <= '0;
        end else if (lpoTick) begin
            pinSyncA <= wakeupPin; // R9
            pinSyncB <= pinSyncA;
            pinPrev <= pinSyncB;
        end
    end

    // ----------------------------------------------------------------
    // Unfiltered pin edge detection
    // ----------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_PINS; i++) begin
            case (pinEdge[2*i +: 2])
                lwpf_pkg::EDGE_RISE: pinHit[i] = pinSyncB[i] && !pinPrev[i]; // R7
                lwpf_pkg::EDGE_FALL: pinHit[i] = !pinSyncB[i] && pinPrev[i];
                lwpf_pkg::EDGE_ANY: pinHit[i] = pinSyncB[i] != pinPrev[i];
                default: pinHit[i] = 1'b0;
            endcase
        end
    end

    assign armed = (state == ST_WATCH); // R6
    assign moduleCause = |(moduleWakeup & moduleWakeupEnable); // R11 R12
    assign wakeCause = (|pinFlag) || (|filterDetectFlag) || moduleCause;

    // ----------------------------------------------------------------
    // Pin filters
    // ----------------------------------------------------------------
    for (genvar f = 0; f < lwpf_pkg::NUM_FILT; f++) begin : g_filt // R10
        lwpf_pin_filter #(
            .FILT_CYCLES(lwpf_pkg::FILT_CYCLES)
        ) u_filt (
            .core_clk(core_clk),
            .arst_n(arst_n),
            .lpoTick(lpoTick),
            .active(armed),
            .edgeSel(filterEdgeSelect[f]),
            .pinLevel(pinSyncB[filterPinSelect[f]]), // R4
            .pinPrev(pinPrev[filterPinSelect[f]]),
            .detect(filtDet[f])
        );
    end

    // ----------------------------------------------------------------
    // Power mode sequence
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= ST_RUN;
            llsWakeIrq <= 1'b0;
            vllsResetReq <= 1'b0;
        end else begin
            llsWakeIrq <= 1'b0;
            vllsResetReq <= 1'b0;
            case (state)
                ST_RUN: begin
                    if (lowLeakageStop || veryLowLeakageStop) begin
                        state <= ST_WATCH;
                    end
                end
                ST_WATCH: begin
                    if (wakeCause && veryLowLeakageStop) begin
                        vllsResetReq <= 1'b1; // R14
                        state <= ST_ISO;
                    end else if (wakeCause) begin
                        llsWakeIrq <= 1'b1; // R13
                        state <= ST_RUN;
                    end else if (!lowLeakageStop && !veryLowLeakageStop) begin
                        state <= ST_RUN;
                    end
                end
                ST_ISO: begin
                    if (ackWrite) begin
                        state <= ST_RUN; // R15
                    end
                end
                default: state <= ST_RUN;
            endcase
        end
    end

    // Isolation and wakeup status; a new event wins over a clear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            ioIsolate <= 1'b0;
            resetStatusWakeup <= 1'b0;
        end else begin
            if (state == ST_WATCH && wakeCause && veryLowLeakageStop) begin
                ioIsolate <= 1'b1; // R15
                resetStatusWakeup <= 1'b1; // R14
            end else begin
                if (ackWrite) begin
                    ioIsolate <= 1'b0;
                end
                if (wrHit && awIdx == lwpf_pkg::IDX_STATUS
                        && wrBits[lwpf_pkg::STAT_WAKE_RST_BIT]) begin
                    resetStatusWakeup <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite write channel
    // ----------------------------------------------------------------
    assign awready = !awHeld;
    assign wready = !wHeld;
    assign wrDo = awHeld && wHeld && !bvalid;
    always_comb begin
        for (int b = 0; b < DW / 8; b++) begin
            wrMask[8*b +: 8] = {8{wStrbQ[b]}};
        end
    end
    assign wrBits = wDataQ & wrMask;
    assign wrHit = wrDo && (awIdx == lwpf_pkg::IDX_PIN_EDGE || awIdx == lwpf_pkg::IDX_MOD_EN
        || awIdx == lwpf_pkg::IDX_PIN_FLAG || awIdx == lwpf_pkg::IDX_FILT_ONE
        || awIdx == lwpf_pkg::IDX_FILT_TWO || awIdx == lwpf_pkg::IDX_STATUS);
    assign ackWrite = wrHit && awIdx == lwpf_pkg::IDX_STATUS
        && wrBits[lwpf_pkg::STAT_ISO_BIT];

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awIdx <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
            bvalid <= 1'b0;
            bresp <= lwpf_pkg::RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                awHeld <= 1'b1;
                awIdx <= awaddr[lwpf_pkg::ADDR_W-1:2];
            end
            if (wvalid && wready) begin
                wHeld <= 1'b1;
                wDataQ <= wdata;
                wStrbQ <= wstrb;
            end
            if (wrDo) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                bvalid <= 1'b1;
                bresp <= wrHit ? lwpf_pkg::RESP_OKAY : lwpf_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    // Only the chip reset clears these; other resets leave the setup intact
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinEdge <= '0; // R5
            moduleWakeupEnable <= '0;
            for (int f = 0; f < lwpf_pkg::NUM_FILT; f++) begin
                filterEdgeSelect[f] <= lwpf_pkg::FILT_EDGE_RESET;
                filterPinSelect[f] <= lwpf_pkg::FILT_SEL_RESET;
            end
        end else if (wrHit) begin
            if (awIdx == lwpf_pkg::IDX_PIN_EDGE) begin
                pinEdge <= (pinEdge & ~wrMask) | wrBits;
            end
            if (awIdx == lwpf_pkg::IDX_MOD_EN) begin
                moduleWakeupEnable <= (moduleWakeupEnable & ~wrMask[NUM_MODS-1:0])
                    | wrBits[NUM_MODS-1:0];
            end
            for (int f = 0; f < lwpf_pkg::NUM_FILT; f++) begin
                if (awIdx == lwpf_pkg::IDX_FILT_ONE + IW'(f) && wStrbQ[0]) begin
                    filterEdgeSelect[f] <= wDataQ[lwpf_pkg::FILT_EDGE_LO +: EW]; // R2
                    filterPinSelect[f] <= wDataQ[lwpf_pkg::FILT_SEL_LO +: SELW]; // R4
                end
            end
        end
    end

    // Sticky flags: a detection in the same cycle as a clear keeps the flag
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            pinFlag <= '0;
            filterDetectFlag <= '0;
        end else begin
            for (int i = 0; i < NUM_PINS; i++) begin
                if (armed && lpoTick && pinHit[i]) begin
                    pinFlag[i] <= 1'b1;
                end else if (wrHit && awIdx == lwpf_pkg::IDX_PIN_FLAG && wrBits[i]) begin
                    pinFlag[i] <= 1'b0;
                end
            end
            for (int f = 0; f < lwpf_pkg::NUM_FILT; f++) begin
                if (armed && filtDet[f]) begin
                    filterDetectFlag[f] <= 1'b1; // R1
                end else if (wrHit && awIdx == lwpf_pkg::IDX_FILT_ONE + IW'(f)
                        && wrBits[lwpf_pkg::FILT_FLAG_BIT]) begin
                    filterDetectFlag[f] <= 1'b0; // R1
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read channel
    // ----------------------------------------------------------------
    assign arready = !rvalid;
    assign arIdx = araddr[lwpf_pkg::ADDR_W-1:2];
    always_comb begin
        next_rdata = '0;
        rdHit = 1'b1;
        case (arIdx)
            lwpf_pkg::IDX_PIN_EDGE: next_rdata = pinEdge;
            lwpf_pkg::IDX_MOD_EN: next_rdata[NUM_MODS-1:0] = moduleWakeupEnable;
            lwpf_pkg::IDX_PIN_FLAG: next_rdata[NUM_PINS-1:0] = pinFlag;
            lwpf_pkg::IDX_FILT_ONE, lwpf_pkg::IDX_FILT_TWO: begin
                next_rdata[lwpf_pkg::FILT_FLAG_BIT] = filterDetectFlag[arIdx[0]];
                next_rdata[lwpf_pkg::FILT_EDGE_LO +: EW] = filterEdgeSelect[arIdx[0]];
                next_rdata[lwpf_pkg::FILT_RSVD_BIT] = 1'b0; // R3
                next_rdata[lwpf_pkg::FILT_SEL_LO +: SELW] = filterPinSelect[arIdx[0]];
            end
            lwpf_pkg::IDX_STATUS: begin
                next_rdata[lwpf_pkg::STAT_ISO_BIT] = ioIsolate;
                next_rdata[lwpf_pkg::STAT_WAKE_RST_BIT] = resetStatusWakeup;
            end
            default: rdHit = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= lwpf_pkg::RESP_OKAY;
        end else if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata <= next_rdata;
            rresp <= rdHit ? lwpf_pkg::RESP_OKAY : lwpf_pkg::RESP_SLVERR;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
        armed && filtDet[0] |=> filterDetectFlag[0])
        else $error("filter flag did not set");

    AST_FLAG_STICKY: assert property (@(posedge core_clk) disable iff (!arst_n) // R1
        filterDetectFlag[1] && !(wrHit && awIdx == lwpf_pkg::IDX_FILT_TWO)
        |=> filterDetectFlag[1])
        else $error("filter flag dropped without a write");

    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!arst_n) // R3
        arvalid && arready && (arIdx == lwpf_pkg::IDX_FILT_ONE || arIdx == lwpf_pkg::IDX_FILT_TWO)
        |=> !rdata[lwpf_pkg::FILT_RSVD_BIT])
        else $error("reserved filter bit read as one");

    AST_IDLE_NO_FLAG: assert property (@(posedge core_clk) disable iff (!arst_n) // R6
        state == ST_RUN && !(lowLeakageStop || veryLowLeakageStop) && !pinFlag[0]
        |=> !pinFlag[0])
        else $error("pin flag set outside low-leakage mode");

    AST_MOD_GATED: assert property (@(posedge core_clk) disable iff (!arst_n) // R12
        $rose(llsWakeIrq) |-> $past(|pinFlag || |filterDetectFlag
            || |(moduleWakeup & moduleWakeupEnable)))
        else $error("wakeup without an enabled source");

    AST_LLS_IRQ: assert property (@(posedge core_clk) disable iff (!arst_n) // R13
        state == ST_WATCH && wakeCause && lowLeakageStop && !veryLowLeakageStop
        |=> llsWakeIrq && state == ST_RUN ##1 !llsWakeIrq)
        else $error("low-leakage wakeup did not raise one interrupt pulse");

    AST_VLLS_STATUS: assert property (@(posedge core_clk) disable iff (!arst_n) // R14
        vllsResetReq |-> resetStatusWakeup && ioIsolate && state == ST_ISO)
        else $error("very-low-leakage wakeup status missing");

    AST_ISO_HOLD: assert property (@(posedge core_clk) disable iff (!arst_n) // R15
        ioIsolate && !ackWrite |=> ioIsolate)
        else $error("isolation released without acknowledge");

    AST_WRITE_RESP: assert property (@(posedge core_clk) disable iff (!arst_n)
        wrDo |=> bvalid)
        else $error("write response missing");

endmodule

// file: testbench/lwpf_wake_src.sv
`timescale 1ns/1ps
// Far side: external pins and peripheral requests, registered so they never race the unit
module lwpf_wake_src (
    // Clock and reset
    input wire logic core_clk,
    input wire logic arst_n,
    // Commands from the bench
    input wire logic [15:0] pinReq,
    input wire logic [7:0] modReq,
    // Levels toward the unit
    output logic [15:0] wakeupPin,
    output logic [7:0] moduleWakeup
);
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wakeupPin <= 16'h0000;
            moduleWakeup <= 8'h00;
        end else begin
            wakeupPin <= pinReq;
            moduleWakeup <= modReq;
        end
    end
endmodule

// file: testbench/lowleak_wakeup_pin_filter_test.sv
`timescale 1ns/1ps
module lowleak_wakeup_pin_filter_test;
    logic core_clk = 1'b0, arst_n = 1'b0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, awready, wready, bvalid, arready, rvalid, low_leakage_stop = 0, vlls = 0;
    logic llsWakeIrq, vllsResetReq, resetStatusWakeup, ioIsolate;
    logic [5:0] awaddr = 6'h00, araddr = 6'h00;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [3:0] wstrb = 4'h0;
    logic [1:0] bresp, rresp, rs;
    logic [15:0] pinReq = 16'h0, wakeupPin;
    logic [7:0] modReq = 8'h0, moduleWakeup;
    int fails = 0, cmp_count = 0;
    localparam logic [5:0] FT = {lwpf_pkg::IDX_FILT_TWO, 2'b00};
    localparam logic [5:0] ST = {lwpf_pkg::IDX_STATUS, 2'b00};
    always #2.5 core_clk = ~core_clk;
    lwpf_wake_src src_u (.core_clk(core_clk), .arst_n(arst_n), .pinReq(pinReq),
        .modReq(modReq), .wakeupPin(wakeupPin), .moduleWakeup(moduleWakeup));
    lwpf_wakeup_unit #(.LPO_DIV(4)) dut_u (.core_clk(core_clk), .arst_n(arst_n),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .wakeupPin(wakeupPin), .moduleWakeup(moduleWakeup), .lowLeakageStop(low_leakage_stop),
        .veryLowLeakageStop(vlls), .llsWakeIrq(llsWakeIrq), .vllsResetReq(vllsResetReq),
        .resetStatusWakeup(resetStatusWakeup), .ioIsolate(ioIsolate));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("Compares %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // Handshakes are judged at the falling edge, where the combinational readies are settled
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        int n = 0;
        logic ta, tw, tb;
        @(posedge core_clk);
        {awvalid, wvalid, bready, awaddr, wdata, wstrb} <= {3'b111, a, d, 4'hf};
        do begin
            @(negedge core_clk);
            {ta, tw, tb, rs} = {awvalid & awready, wvalid & wready, bvalid, bresp};
            @(posedge core_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            n++;
        end while (!tb && n < 50);
        bready <= 1'b0;
        if (!tb) begin fails++; stop_test(); end
    endtask
    task automatic rdw(input logic [5:0] a);
        int n = 0;
        logic ta, tr;
        @(posedge core_clk);
        {arvalid, rready, araddr} <= {2'b11, a};
        do begin
            @(negedge core_clk);
            {ta, tr, rd, rs} = {arvalid & arready, rvalid, rdata, rresp};
            @(posedge core_clk);
            if (ta) arvalid <= 1'b0;
            n++;
        end while (!tr && n < 50);
        rready <= 1'b0;
        if (!tr) begin fails++; stop_test(); end
    endtask
    // A pulse stands one cycle, so it is looked for at every falling edge
    task automatic waitp(input logic vl);
        int n = 0;
        do @(negedge core_clk); while ((vl ? vllsResetReq : llsWakeIrq) !== 1'b1 && ++n < 200);
        if (n >= 200) begin fails++; stop_test(); end
    endtask
    initial begin
        repeat (16) @(posedge core_clk);
        arst_n <= 1'b1;
        rdw(FT); chk(rd, 32'h0);
        wr(FT, 32'hff); chk(32'(rs), 32'(lwpf_pkg::RESP_OKAY));
        rdw(FT); chk(rd, 32'h6f);
        wr(FT, 32'h2f); rdw(FT); chk(rd, 32'h2f);
        rdw(6'h3c); chk(rd, 32'h0);
        chk(32'(rs), 32'(lwpf_pkg::RESP_SLVERR));
        wr(6'h3c, 32'h0); chk(32'(rs), 32'(lwpf_pkg::RESP_SLVERR));
        repeat (40) @(posedge core_clk);
        low_leakage_stop <= 1'b1;
        repeat (4) @(posedge core_clk);
        pinReq <= 16'h8000;
        waitp(1'b0); chk(32'(vllsResetReq), 32'h0);
        @(posedge core_clk); low_leakage_stop <= 1'b0;
        rdw(FT); chk(rd, 32'haf);
        pinReq <= 16'h0;
        wr(FT, 32'haf); rdw(FT); chk(rd, 32'h2f);
        wr(6'h00, 32'h1); low_leakage_stop <= 1'b1; pinReq <= 16'h0001;
        waitp(1'b0); @(posedge core_clk); low_leakage_stop <= 1'b0; pinReq <= 16'h0;
        rdw(6'h14); chk(rd, 32'h1);
        wr(6'h14, 32'h1); rdw(6'h14); chk(rd, 32'h0);
        wr(6'h10, 32'h2); vlls <= 1'b1; modReq <= 8'h01;
        repeat (40) @(posedge core_clk);
        @(negedge core_clk); chk(32'(vllsResetReq | ioIsolate), 32'h0);
        @(posedge core_clk); modReq <= 8'h02;
        waitp(1'b1); @(posedge core_clk); vlls <= 1'b0; modReq <= 8'h0;
        @(negedge core_clk); chk(32'({ioIsolate, resetStatusWakeup}), 32'h3);
        rdw(ST); chk(rd, 32'h3);
        wr(ST, 32'h1); @(negedge core_clk); chk(32'(ioIsolate), 32'h0);
        stop_test();
    end
endmodule
